// >>> core_pkg.sv
// Shared constants and types of the instruction timing and decode core
package core_pkg;
  // ************************************************************
  // Widths and timing
  // ************************************************************
  localparam int PC_W = 10;        // Program counter width
  localparam int DM_AW = 7;        // Data memory address width
  localparam int DW = 8;           // Data byte width
  localparam int IW = 16;          // Instruction word width
  localparam int STACK_DEPTH = 6;  // Return stack levels
  localparam int SP_W = 3;         // Stack pointer width
  localparam int PHASES = 4;       // Clock periods per instruction cycle
  localparam int OP_LSB = 10;      // Opcode field position
  localparam int OP_W = 6;         // Opcode field width
  localparam int BIT_LSB = 7;      // Bit index field position
  localparam int BIT_W = 3;        // Bit index field width
  // Phases of one instruction cycle
  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_EXEC = 2'h2;
  localparam logic [1:0] PH_STEP = 2'h1;
  // Fixed values
  localparam logic [DM_AW-1:0] PROGRAM_COUNTER_LOW_BYTE_ADDR = 7'h06;
  localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] BYTE_ONE = 8'h01;
  localparam logic [DW:0] BYTE_MAX = 9'h0FF;
  localparam logic [SP_W-1:0] SP_LAST = SP_W'(STACK_DEPTH - 1);
  localparam logic [SP_W-1:0] SP_ONE = 3'h1;
  // ************************************************************
  // Types
  // ************************************************************
  typedef logic [PC_W-1:0] pc_t;   // Program address
  typedef logic [DW-1:0] byte_t;   // Data byte
  localparam pc_t PC_ONE = 10'h001;
  localparam pc_t PC_TWO = 10'h002;
  // Operations, in opcode order
  typedef enum logic [OP_W-1:0] {
    nop_op, add_mem_op, add_imm_op, addc_mem_op, add_store_op,
    sub_mem_op, sub_imm_op, subc_mem_op, sub_store_op,
    and_mem_op, or_mem_op, xor_mem_op, and_imm_op, or_imm_op, xor_imm_op,
    and_store_op, or_store_op, xor_store_op, complement_op, complement_to_acc_op,
    increment_memory_op, increment_to_accumulator_op,
    decrement_memory_op, decrement_to_accumulator_op,
    rotate_right_op, rotate_left_op, rotate_right_carry_op, rotate_left_carry_op,
    move_to_acc_op, move_to_mem_op, move_imm_op, bit_set_op, bit_clear_op,
    skip_zero_op, skip_bit_zero_op, skip_bit_set_op, skip_inc_zero_op,
    skip_dec_zero_op, unconditional_jump_op, subroutine_call_op,
    subroutine_return_op, interrupt_return_op, table_read_op, halt_op,
    watchdog_clear_op
  } op_e;
  // Core flags
  typedef struct packed {
    logic int_enable;  // Set by return from interrupt
    logic halted;      // Power-down state
    logic zero;        // Zero flag
    logic carry;       // Carry, set means no borrow on subtract
  } flags_s;
  // Data memory request
  typedef struct packed {
    logic we;
    logic [DM_AW-1:0] waddr;
    byte_t wdata;
    logic [DM_AW-1:0] raddr;
  } ram_req_s;
  // Whole core state
  typedef struct packed {
    logic [1:0] ph;                              // Phase in instruction cycle
    logic extra;                                 // Second cycle in progress
    logic [IW-1:0] ir;                           // Executing instruction
    logic [IW-1:0] tbl_word;                     // Fetched table word
    pc_t pc;                                     // Program counter
    pc_t prog_addr;                              // Program memory address
    byte_t acc;                                  // Accumulator
    flags_s flags;                               // Flags
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;     // Return stack
    logic [SP_W-1:0] sp;                         // Next free stack slot
    byte_t tbl_high;                             // Table word high byte
    logic wdt_clear;                             // Watchdog clear pulse
    logic retire;                                // Instruction end pulse
    logic wake_meta;                             // Wake synchroniser stage 1
    logic wake_sync;                             // Wake synchroniser stage 2
  } core_state_s;
endpackage : core_pkg

// >>> data_ram.sv
// Data memory with registered read data
`timescale 1ns/1ps
module data_ram #(
  parameter int WORDS = 128
) (
  input wire logic clk_sys,
  input core_pkg::ram_req_s req,
  output core_pkg::byte_t rdata
);
  import core_pkg::*;

  // Depth must fit the address field
  if (WORDS < 1 || WORDS > (1 << DM_AW)) begin : g_bad_depth
    $error("data_ram depth does not fit the address width");
  end

  byte_t mem [WORDS];  // Storage array

  // Write port and registered read port
  always_ff @(posedge clk_sys) begin
    if (req.we) begin
      mem[req.waddr] <= req.wdata;
    end
    rdata <= mem[req.raddr];
  end
endmodule : data_ram

// >>> instruction_timing_decode.sv
// Instruction sequencing, timing and execution of the accumulator core
`timescale 1ns/1ps
// Summary of operation
// - Instruction cycle is four system clocks
// - Jumps, calls, returns, table reads: two cycles
// - Writing counter low byte adds a cycle
// - Taken skip two cycles, otherwise one
// - Conditional tests skip the next instruction
// - Call saves address after call for return
// - Jump loads target, saves nothing
// - Carry above 255, borrow below zero
// - Increment and decrement change by one
// - Logic results of zero set zero flag
// - Logic operands pass through the accumulator, except for the complements
// - Rotates shift one bit, carry variants included
// - Three move forms between memory, accumulator, immediate
// - Bit set and clear keep other bits
// - Table read moves program word low byte to memory, high byte to tbl_high
// - Halt powers down; watchdog clear instruction
// - Skip and counter low writes cost cycles
module instruction_timing_decode #(
  parameter int RAM_WORDS = 128
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [core_pkg::IW-1:0] prog_data,
  input wire logic wake_pin,
  output core_pkg::pc_t prog_addr,
  output core_pkg::byte_t acc,
  output core_pkg::flags_s flags,
  output core_pkg::byte_t tbl_high,
  output logic wdt_clear,
  output logic retire
);
  import core_pkg::*;

  // ************************************************************
  // Checks and helpers
  // ************************************************************
  if (PHASES != 4 || STACK_DEPTH > (1 << SP_W) || PC_W <= DW) begin : g_bad_cfg
    $error("instruction_timing_decode configuration not supported");
  end

  // Byte add with carry in, carry out in the top bit
  function automatic logic [DW:0] add_byte(input byte_t a, input byte_t b, input logic cin);
    add_byte = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, cin};
  endfunction : add_byte

  // One-hot mask for a bit index
  function automatic byte_t bit_mask(input logic [BIT_W-1:0] idx);
    bit_mask = BYTE_ONE << idx;
  endfunction : bit_mask

  // Stack pointer step with wrap over the stack depth
  function automatic logic [SP_W-1:0] sp_step(input logic [SP_W-1:0] sp, input logic up);
    if (up) begin
      sp_step = (sp == SP_LAST) ? '0 : sp + SP_ONE;
    end else begin
      sp_step = (sp == '0) ? SP_LAST : sp - SP_ONE;
    end
  endfunction : sp_step

  // ************************************************************
  // State and decode
  // ************************************************************
  core_state_s st_r;     // Registered state
  core_state_s st_nxt;   // Next state
  ram_req_s ram_req;     // Data memory request
  byte_t ram_rdata;      // Data memory read data
  op_e op;               // Decoded operation
  byte_t opnd;           // Memory operand
  byte_t imm;            // Immediate operand
  logic [BIT_W-1:0] bidx;  // Bit index
  logic pcl_hit;         // Operand is the program counter low byte
  logic exec_cyc;        // Execute phase of a first cycle
  logic skip;            // Skip taken
  logic two_cyc;         // Instruction needs a second cycle
  logic wr_mem;          // Result goes to memory
  logic wr_acc;          // Result goes to accumulator
  logic arith;           // Result from the adder
  logic set_z;           // Update zero flag
  logic set_c;           // Update carry flag
  logic newc;            // New carry
  byte_t res;            // Operation result
  logic [DW:0] sum;      // Adder output
  pc_t target;           // Next program counter

  assign op = op_e'(st_r.ir[OP_LSB +: OP_W]);
  assign imm = st_r.ir[DW-1:0];
  assign bidx = st_r.ir[BIT_LSB +: BIT_W];
  assign pcl_hit = (st_r.ir[DM_AW-1:0] == PROGRAM_COUNTER_LOW_BYTE_ADDR);
  // Counter low byte reads back the current counter
  assign opnd = pcl_hit ? st_r.pc[DW-1:0] : ram_rdata;
  assign exec_cyc = (st_r.ph == PH_EXEC) && !st_r.extra;

  // Data memory
  data_ram #(
    .WORDS(RAM_WORDS)
  ) u_ram (
    .clk_sys(clk_sys),
    .req(ram_req),
    .rdata(ram_rdata)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    res = BYTE_ZERO;
    sum = '0;
    arith = 1'b0;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    set_z = 1'b0;
    set_c = 1'b0;
    skip = 1'b0;
    two_cyc = 1'b0;
    newc = st_r.flags.carry;
    target = pc_t'(st_r.pc + PC_ONE);
    st_nxt = st_r;
    st_nxt.wdt_clear = 1'b0;
    st_nxt.retire = 1'b0;
    st_nxt.wake_meta = wake_pin;
    st_nxt.wake_sync = st_r.wake_meta;
    ram_req = '0;
    ram_req.raddr = st_r.ir[DM_AW-1:0];
    ram_req.waddr = st_r.ir[DM_AW-1:0];
    // Phase counter stands while powered down
    if (st_r.flags.halted) begin
      if (st_r.wake_sync) begin
        st_nxt.flags.halted = 1'b0;
      end
    end else begin
      st_nxt.ph = st_r.ph + PH_STEP;
    end
    // Fetch; a second cycle keeps the instruction and takes the table word
    if (!st_r.flags.halted && st_r.ph == PH_FETCH) begin
      if (st_r.extra) begin
        st_nxt.tbl_word = prog_data;
      end else begin
        st_nxt.ir = prog_data;
      end
    end
    // Second cycle: refetch from the new counter, finish table read
    if (st_r.ph == PH_EXEC && st_r.extra) begin
      st_nxt.extra = 1'b0;
      st_nxt.prog_addr = st_r.pc;
      st_nxt.retire = 1'b1;
      if (op == table_read_op) begin
        ram_req.we = 1'b1;
        ram_req.wdata = st_r.tbl_word[DW-1:0];
        st_nxt.tbl_high = st_r.tbl_word[IW-1:DW];
      end
    end
    // Execute
    if (exec_cyc) begin
      case (op)
        // Arithmetic, carry out of the adder
        add_mem_op: begin
          sum = add_byte(st_r.acc, opnd, 1'b0);
          arith = 1'b1;
          wr_acc = 1'b1;
        end
        add_imm_op: begin
          sum = add_byte(st_r.acc, imm, 1'b0);
          arith = 1'b1;
          wr_acc = 1'b1;
        end
        addc_mem_op: begin
          sum = add_byte(st_r.acc, opnd, st_r.flags.carry);
          arith = 1'b1;
          wr_acc = 1'b1;
        end
        add_store_op: begin
          sum = add_byte(st_r.acc, opnd, 1'b0);
          arith = 1'b1;
          wr_mem = 1'b1;
        end
        // Subtract as add of complement, carry clear on borrow
        sub_mem_op: begin
          sum = add_byte(st_r.acc, ~opnd, 1'b1);
          arith = 1'b1;
          wr_acc = 1'b1;
        end
        sub_imm_op: begin
          sum = add_byte(st_r.acc, ~imm, 1'b1);
          arith = 1'b1;
          wr_acc = 1'b1;
        end
        subc_mem_op: begin
          sum = add_byte(st_r.acc, ~opnd, st_r.flags.carry);
          arith = 1'b1;
          wr_acc = 1'b1;
        end
        sub_store_op: begin
          sum = add_byte(st_r.acc, ~opnd, 1'b1);
          arith = 1'b1;
          wr_mem = 1'b1;
        end
        // Logic, one operand the accumulator except for the complements
        and_mem_op: begin res = st_r.acc & opnd; wr_acc = 1'b1; set_z = 1'b1; end
        or_mem_op: begin res = st_r.acc | opnd; wr_acc = 1'b1; set_z = 1'b1; end
        xor_mem_op: begin res = st_r.acc ^ opnd; wr_acc = 1'b1; set_z = 1'b1; end
        and_imm_op: begin res = st_r.acc & imm; wr_acc = 1'b1; set_z = 1'b1; end
        or_imm_op: begin res = st_r.acc | imm; wr_acc = 1'b1; set_z = 1'b1; end
        xor_imm_op: begin res = st_r.acc ^ imm; wr_acc = 1'b1; set_z = 1'b1; end
        and_store_op: begin res = st_r.acc & opnd; wr_mem = 1'b1; set_z = 1'b1; end
        or_store_op: begin res = st_r.acc | opnd; wr_mem = 1'b1; set_z = 1'b1; end
        xor_store_op: begin res = st_r.acc ^ opnd; wr_mem = 1'b1; set_z = 1'b1; end
        complement_op: begin res = ~opnd; wr_mem = 1'b1; set_z = 1'b1; end
        complement_to_acc_op: begin res = ~opnd; wr_acc = 1'b1; set_z = 1'b1; end
        // Step by one
        increment_memory_op: begin res = opnd + BYTE_ONE; wr_mem = 1'b1; set_z = 1'b1; end
        increment_to_accumulator_op: begin res = opnd + BYTE_ONE; wr_acc = 1'b1; set_z = 1'b1; end
        decrement_memory_op: begin res = opnd - BYTE_ONE; wr_mem = 1'b1; set_z = 1'b1; end
        decrement_to_accumulator_op: begin res = opnd - BYTE_ONE; wr_acc = 1'b1; set_z = 1'b1; end
        // Rotates by one bit
        rotate_right_op: begin res = {opnd[0], opnd[DW-1:1]}; wr_mem = 1'b1; end
        rotate_left_op: begin res = {opnd[DW-2:0], opnd[DW-1]}; wr_mem = 1'b1; end
        rotate_right_carry_op: begin
          res = {st_r.flags.carry, opnd[DW-1:1]};
          newc = opnd[0];
          set_c = 1'b1;
          wr_mem = 1'b1;
        end
        rotate_left_carry_op: begin
          res = {opnd[DW-2:0], st_r.flags.carry};
          newc = opnd[DW-1];
          set_c = 1'b1;
          wr_mem = 1'b1;
        end
        // Moves
        move_to_acc_op: begin res = opnd; wr_acc = 1'b1; end
        move_to_mem_op: begin res = st_r.acc; wr_mem = 1'b1; end
        move_imm_op: begin res = imm; wr_acc = 1'b1; end
        // Bit operations, read-modify-write inside the core
        bit_set_op: begin res = opnd | bit_mask(bidx); wr_mem = 1'b1; end
        bit_clear_op: begin res = opnd & ~bit_mask(bidx); wr_mem = 1'b1; end
        // Conditional skips
        skip_zero_op: skip = (opnd == BYTE_ZERO);
        skip_bit_zero_op: skip = ((opnd & bit_mask(bidx)) == BYTE_ZERO);
        skip_bit_set_op: skip = ((opnd & bit_mask(bidx)) != BYTE_ZERO);
        skip_inc_zero_op: begin
          res = opnd + BYTE_ONE;
          wr_mem = 1'b1;
          skip = (res == BYTE_ZERO);
        end
        skip_dec_zero_op: begin
          res = opnd - BYTE_ONE;
          wr_mem = 1'b1;
          skip = (res == BYTE_ZERO);
        end
        // Control transfer
        unconditional_jump_op: begin
          target = st_r.ir[PC_W-1:0];
          two_cyc = 1'b1;
        end
        subroutine_call_op: begin
          st_nxt.stack[st_r.sp] = pc_t'(st_r.pc + PC_ONE);
          st_nxt.sp = sp_step(st_r.sp, 1'b1);
          target = st_r.ir[PC_W-1:0];
          two_cyc = 1'b1;
        end
        subroutine_return_op, interrupt_return_op: begin
          st_nxt.sp = sp_step(st_r.sp, 1'b0);
          target = st_r.stack[sp_step(st_r.sp, 1'b0)];
          two_cyc = 1'b1;
          if (op == interrupt_return_op) begin
            st_nxt.flags.int_enable = 1'b1;
          end
        end
        table_read_op: two_cyc = 1'b1;
        // Power down and watchdog
        halt_op: st_nxt.flags.halted = 1'b1;
        watchdog_clear_op: st_nxt.wdt_clear = 1'b1;
        default: ;
      endcase
      if (arith) begin
        res = sum[DW-1:0];
        newc = sum[DW];
        set_z = 1'b1;
        set_c = 1'b1;
      end
      if (wr_acc) begin
        st_nxt.acc = res;
      end
      if (set_z) begin
        st_nxt.flags.zero = (res == BYTE_ZERO);
      end
      if (set_c) begin
        st_nxt.flags.carry = newc;
      end
      // Memory write; counter low byte write acts as a jump
      if (wr_mem) begin
        if (pcl_hit) begin
          target = {st_r.pc[PC_W-1:DW], res};
          two_cyc = 1'b1;
        end else begin
          ram_req.we = 1'b1;
          ram_req.wdata = res;
        end
      end
      if (skip) begin
        target = pc_t'(st_r.pc + PC_TWO);
        two_cyc = 1'b1;
      end
      st_nxt.pc = target;
      if (two_cyc) begin
        st_nxt.extra = 1'b1;
        if (op == table_read_op) begin
          st_nxt.prog_addr = {st_r.pc[PC_W-1:DW], st_r.acc};
        end
      end else begin
        st_nxt.prog_addr = target;
        st_nxt.retire = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign prog_addr = st_r.prog_addr;
  assign acc = st_r.acc;
  assign flags = st_r.flags;
  assign tbl_high = st_r.tbl_high;
  assign wdt_clear = st_r.wdt_clear;
  assign retire = st_r.retire;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Second cycle lasts one instruction cycle
  sequence s_bubble;
    st_r.extra [*4] ##1 !st_r.extra;
  endsequence

  a_cycle_ring: assert property (
    !st_r.flags.halted |=> st_r.ph == $past(st_r.ph) + PH_STEP)
    else $error("phase did not advance by one");
  a_branch_two: assert property (
    exec_cyc && (op inside {unconditional_jump_op, subroutine_call_op,
      subroutine_return_op, interrupt_return_op, table_read_op}) |=> s_bubble)
    else $error("control transfer not two cycles");
  a_pcl_extra: assert property (
    exec_cyc && wr_mem && pcl_hit |=> s_bubble)
    else $error("counter low write without extra cycle");
  a_skip_taken: assert property (
    exec_cyc && skip |=> s_bubble)
    else $error("taken skip not two cycles");
  a_single_cycle: assert property (
    exec_cyc && !two_cyc |=> !st_r.extra [*4])
    else $error("one-cycle instruction got extra cycle");
  a_skip_target: assert property (
    exec_cyc && skip |=> st_r.pc == pc_t'($past(st_r.pc) + PC_TWO))
    else $error("skip did not pass next instruction");
  a_call_save: assert property (
    exec_cyc && op == subroutine_call_op |=>
      st_r.stack[sp_step(st_r.sp, 1'b0)] == pc_t'($past(st_r.pc) + PC_ONE)
      && st_r.pc == $past(st_r.ir[PC_W-1:0]))
    else $error("call saved wrong return address");
  a_jump_nosave: assert property (
    exec_cyc && op == unconditional_jump_op |=>
      $stable(st_r.sp) && st_r.pc == $past(st_r.ir[PC_W-1:0]))
    else $error("jump touched stack or missed target");
  a_add_carry: assert property (
    exec_cyc && op == add_mem_op |=>
      st_r.flags.carry == (({1'b0, $past(st_r.acc)} + {1'b0, $past(opnd)}) > BYTE_MAX))
    else $error("add carry wrong");
  a_logic_zero: assert property (
    exec_cyc && (op inside {and_mem_op, and_imm_op, xor_imm_op}) |=>
      st_r.flags.zero == (st_r.acc == BYTE_ZERO))
    else $error("zero flag wrong after logic");
  a_bit_clear: assert property (
    exec_cyc && op == bit_clear_op && !pcl_hit |->
      ram_req.we && !ram_req.wdata[bidx]
      && ((ram_req.wdata | bit_mask(bidx)) == (opnd | bit_mask(bidx))))
    else $error("bit clear disturbed other bits");
  a_halt_hold: assert property (
    exec_cyc && op == halt_op |=> st_r.flags.halted ##1 $stable(st_r.pc))
    else $error("halt did not stop the core");
endmodule : instruction_timing_decode

// >>> prog_rom.sv
// Program memory model answering the core's fetch address
`timescale 1ns/1ps
module prog_rom (
  input wire logic clk_sys,
  input wire core_pkg::pc_t prog_addr,
  output logic [core_pkg::IW-1:0] prog_data
);
  import core_pkg::*;
  // Program words, loaded by the bench before reset is released
  logic [IW-1:0] mem [0:(1<<PC_W)-1];
  // ************************************************************
  // Registered read
  // ************************************************************
  // One clock after the address, inside the two clocks the core allows
  always_ff @(posedge clk_sys) begin
    prog_data <= mem[prog_addr];
  end
endmodule : prog_rom

// >>> test_instruction_timing_decode.sv
// Self-checking bench for the instruction timing and decode core
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_instruction_timing_decode;
  import core_pkg::*;
  // ************************************************************
  // Signals and counters
  // ************************************************************
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic wake_pin = 1'b0;
  logic [IW-1:0] prog_data;
  pc_t prog_addr;
  pc_t hold_addr;
  byte_t acc;
  byte_t tbl_high;
  flags_s flags;
  logic wdt_clear;
  logic retire;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int wdt_seen = 0;
  always #2.5 clk_sys = ~clk_sys;
  instruction_timing_decode u_instruction_timing_decode (.clk_sys(clk_sys), .rstn(rstn),
    .prog_data(prog_data), .wake_pin(wake_pin), .prog_addr(prog_addr), .acc(acc),
    .flags(flags), .tbl_high(tbl_high), .wdt_clear(wdt_clear), .retire(retire));
  prog_rom u_prog_rom (.clk_sys(clk_sys), .prog_addr(prog_addr), .prog_data(prog_data));
  // Watchdog pulse count and hang limit
  always @(posedge clk_sys) begin
    cycles++;
    if (wdt_clear === 1'b1) wdt_seen++;
    if (cycles == 3000) begin
      num_errors++;
      end_sim();
    end
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Program image; skipped slots hold 0x55 loads that must never land
  task automatic load();
    logic [IW-1:0] p [$] = '{{move_imm_op, 10'h0FF}, {add_imm_op, 10'h001},
      {sub_imm_op, 10'h001}, {move_to_mem_op, 10'h010}, {increment_to_accumulator_op, 10'h010},
      {decrement_to_accumulator_op, 10'h010}, {xor_imm_op, 10'h0FE}, {or_imm_op, 10'h081},
      {move_to_mem_op, 10'h011}, {bit_clear_op, 10'h011}, {rotate_left_carry_op, 10'h011},
      {move_to_acc_op, 10'h011}, {rotate_right_carry_op, 10'h011}, {move_to_acc_op, 10'h011},
      {skip_zero_op, 10'h010}, {move_imm_op, 10'h000}, {move_to_mem_op, 10'h012},
      {skip_zero_op, 10'h012}, {move_imm_op, 10'h055}, {move_imm_op, 10'h033},
      {subroutine_call_op, 10'h018}, {add_imm_op, 10'h001}, {unconditional_jump_op, 10'h01A},
      {move_imm_op, 10'h055}, {move_imm_op, 10'h0A5}, {subroutine_return_op, 10'h000},
      {move_imm_op, 10'h020}, {move_to_mem_op, 10'h006}, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, {move_imm_op, 10'h02F}, {table_read_op, 10'h014}, {move_to_acc_op, 10'h014},
      {subroutine_call_op, 10'h028}, {watchdog_clear_op, 10'h000}, {halt_op, 10'h000},
      {move_imm_op, 10'h099}, {unconditional_jump_op, 10'h030}};
    // Second image from 0x30: memory add, plain rotates, complement, bit skips
    logic [IW-1:0] q [$] = '{{add_mem_op, 10'h010}, {decrement_memory_op, 10'h011},
      {rotate_right_op, 10'h011}, {move_to_acc_op, 10'h011}, {rotate_left_op, 10'h011},
      {complement_op, 10'h010}, {move_to_acc_op, 10'h011}, {skip_bit_set_op, 10'h391},
      {bit_set_op, 10'h391}, {skip_bit_set_op, 10'h391}, {move_imm_op, 10'h055},
      {skip_inc_zero_op, 10'h011}, {move_imm_op, 10'h055}, {move_to_acc_op, 10'h011}};
    for (int i = 0; i < 1024; i++) u_prog_rom.mem[i] = (i < p.size()) ? p[i] : 16'h0000;
    u_prog_rom.mem[10'h028] = {interrupt_return_op, 10'h000};
    u_prog_rom.mem[10'h02F] = 16'h3C5A;
    foreach (q[i]) u_prog_rom.mem[10'h030 + i] = q[i];
  endtask : load
  // Wait for the next instruction end and check clocks since the last one
  task automatic ret(input int n);
    int k;
    k = 0;
    do begin @(posedge clk_sys); #1; k++; end while (retire !== 1'b1 && k < 40);
    if (n > 0) `CHK(k, n)
  endtask : ret
  // Ends the run with the counts and the verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // ************************************************************
  // Scenarios
  // ************************************************************
  // Immediate load, add carry out, subtract borrow, inc and dec from memory
  task automatic t_arith();
    ret(0);
    `CHK(acc, 8'hFF)
    ret(4);
    `CHK({acc, flags.zero, flags.carry}, 10'h003)
    ret(4);
    `CHK({acc, flags.carry}, 9'h1FE)
    ret(4);
    ret(4);
    `CHK({acc, flags.zero}, 9'h001)
    ret(4);
    `CHK(acc, 8'hFE)
    $display("end t_arith");
  endtask : t_arith
  // Logic zero flag, bit clear and rotates through carry
  task automatic t_logic();
    ret(4);
    `CHK({acc, flags.zero}, 9'h001)
    ret(4);
    `CHK({acc, flags.zero}, 9'h102)
    repeat (3) ret(4);
    `CHK(flags.carry, 1'b1)
    ret(4);
    `CHK(acc, 8'h00)
    ret(4);
    `CHK(flags.carry, 1'b0)
    ret(4);
    `CHK(acc, 8'h80)
    $display("end t_logic");
  endtask : t_logic
  // Skip not taken, then taken past a load that must not run
  task automatic t_skip();
    ret(4);
    ret(4);
    ret(4);
    ret(8);
    ret(4);
    `CHK(acc, 8'h33)
    $display("end t_skip");
  endtask : t_skip
  // Call and return, jump, counter low write, table read
  task automatic t_flow();
    ret(8);
    ret(4);
    ret(8);
    ret(4);
    `CHK(acc, 8'hA6)
    ret(8);
    ret(4);
    `CHK(acc, 8'h20)
    ret(8);
    ret(4);
    `CHK(acc, 8'h2F)
    ret(8);
    `CHK(tbl_high, 8'h3C)
    ret(4);
    `CHK(acc, 8'h5A)
    $display("end t_flow");
  endtask : t_flow
  // Interrupt return, watchdog clear, halt and wake
  task automatic t_misc();
    ret(8);
    ret(8);
    `CHK(flags.int_enable, 1'b1)
    ret(4);
    ret(4);
    `CHK(flags.halted, 1'b1)
    hold_addr = prog_addr;
    repeat (16) @(posedge clk_sys);
    `CHK(prog_addr, hold_addr)
    #1 wake_pin = 1'b1;
    ret(0);
    wake_pin = 1'b0;
    `CHK({acc, flags.halted}, 9'h132)
    `CHK(wdt_seen, 1)
    $display("end t_misc");
  endtask : t_misc
  // Memory add, decrement, plain rotates, complement and bit skips
  task automatic t_more();
    ret(8);
    ret(4);
    `CHK({acc, flags.zero, flags.carry}, 10'h261)
    repeat (3) ret(4);
    `CHK({acc, flags.carry}, 9'h17F)
    ret(4);
    ret(4);
    `CHK(flags.zero, 1'b1)
    ret(4);
    `CHK(acc, 8'h7F)
    ret(4);
    ret(4);
    ret(8);
    ret(8);
    ret(4);
    `CHK(acc, 8'h00)
    $display("end t_more");
  endtask : t_more
  // Main sequence
  initial begin
    load();
    repeat (8) @(posedge clk_sys);
    #1 rstn = 1'b1;
    t_arith();
    t_logic();
    t_skip();
    t_flow();
    t_misc();
    t_more();
    end_sim();
  end
endmodule : test_instruction_timing_decode
